// ### rtl/rcdl_config_loader.sv
/*
 * Reset configuration loader with one port's pin drivers: a four-byte
 * nonvolatile latch array reached over AHB-Lite, a boot sequencer that
 * copies it into the applied configuration after each reset, and the
 * per-pin drive-mode decoder.
 * Assumes an AHB-Lite master with single word transfers, a 25 MHz hclk,
 * and a power-on reset por_n that only clears the latch array.
 */
`timescale 1ns/10ps

// Summary of operation
// - Four latch bytes applied at every reset
// - Port reset drive fields packed in bytes 0-2
// - Reset field: analog, digital, pull-up, pull-down
// - Top of byte 2 makes pin an external reset
// - Bit 6 of byte 2 gates debug access
// - Bit 0 of byte 3 picks boot clock speed
// - Two bits in byte 3 pick debug port
// - Bit 3 of byte 3 enables flash correction
// - Byte 3 top nibble sets clock phase delay
// - Each pin has its own three-bit mode
// - Modes 0 and 1 leave pin floating
// - Mode 2: resistive high, strong low
// - Mode 3: strong high, resistive low
// - Modes 4 and 5 are open drain
// - Mode 6 strong, mode 7 resistive both ways
// - Output from fabric or data register
// - Input always to pin state, fabric if enabled in a non-analog mode after boot
module rcdl_config_loader
    import rcdl_pkg::*;
#(
    parameter int PINS = 8,
    parameter int PORT_NUM = 1,
    parameter int XRES_PORT = 1,
    parameter int XRES_PIN = 2,
    parameter logic [3:0] PHASE_DEFAULT = 4'h0
) (
    // Clock and resets
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Digital fabric side of the pins
    input wire logic [PINS-1:0] fabric_out,
    output logic [PINS-1:0] fabric_in,
    // Pins
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pin_pull_up,
    output logic [PINS-1:0] pin_pull_down,
    output logic [PINS-1:0] pin_analog,
    // Applied configuration
    output logic core_reset_n,
    output logic ext_reset_req,
    output logic ext_reset_pin_select,
    output logic debug_access_enable,
    output logic [1:0] debug_port_select,
    output logic debug_port_enable,
    output logic boot_clock_speed_select,
    output logic flash_correction_enable,
    output logic [3:0] digital_clock_phase_delay
);

    localparam int RDM_LSB = rcdl_rdm_lsb(PORT_NUM);
    localparam bit HAS_XRES = (PORT_NUM == XRES_PORT) && (XRES_PIN < PINS);
    localparam logic [7:0] DEF_BYTE3 = {PHASE_DEFAULT, RCDL_DEF_BYTE3[3:0]};

    typedef struct packed {
        rcdl_boot_t boot;
        logic [RCDL_LAT_AW-1:0] load_idx;
        logic [31:0] active_cfg;
        logic [3*PINS-1:0] drive_mode;
        logic [PINS-1:0] data;
        logic [PINS-1:0] hw_out_en;
        logic [PINS-1:0] dig_in_en;
        logic [PINS-1:0] pin_state;
        logic [PINS-1:0] pin_out;
        logic [PINS-1:0] pin_oe;
        logic [PINS-1:0] pin_pu;
        logic [PINS-1:0] pin_pd;
        logic [PINS-1:0] pin_an;
        logic [PINS-1:0] fab_in;
        logic ext_req;
        logic [15:0] lat_writes;
        logic dp_write;
        logic [5:0] dp_idx;
        logic [31:0] rdata;
    } rcdl_state_t;

    rcdl_state_t s_q;
    rcdl_state_t s_d;

    // Nonvolatile cells: survive hresetn, cleared only at power-on
    logic [7:0] lat_mem [RCDL_LAT_BYTES];
    logic lat_we;
    logic [RCDL_LAT_AW-1:0] lat_waddr;
    logic [7:0] lat_wdata;

    logic addr_take;
    logic [2:0] eff_mode [PINS];
    logic eff_bit [PINS];

    // Pin drive decode: {oe, out, pull_up, pull_down}
    function automatic logic [3:0] decode_drive(input logic [2:0] mode, input logic dbit);
        logic [3:0] r;
        r = 4'h0;
        unique case (mode)
            RCDL_PM_HIZ_ANALOG, RCDL_PM_HIZ_DIGITAL: r = 4'h0;
            RCDL_PM_RES_UP: r = dbit ? 4'h2 : 4'h8;
            RCDL_PM_RES_DOWN: r = dbit ? 4'hc : 4'h1;
            RCDL_PM_OD_LOW: r = dbit ? 4'h0 : 4'h8;
            RCDL_PM_OD_HIGH: r = dbit ? 4'hc : 4'h0;
            RCDL_PM_STRONG: r = {1'b1, dbit, 2'b00};
            RCDL_PM_RES_BOTH: r = {2'b00, dbit, ~dbit};
        endcase
        return r;
    endfunction : decode_drive

    // Reset drive field to mode and data bit used until boot ends
    function automatic logic [3:0] reset_drive(input logic [1:0] field);
        logic [3:0] r;
        r = {RCDL_PM_HIZ_ANALOG, 1'b0};
        unique case (field)
            RCDL_RDM_HIZ_ANALOG: r = {RCDL_PM_HIZ_ANALOG, 1'b0};
            RCDL_RDM_HIZ_DIGITAL: r = {RCDL_PM_HIZ_DIGITAL, 1'b0};
            RCDL_RDM_PULL_UP: r = {RCDL_PM_RES_UP, 1'b1};
            RCDL_RDM_PULL_DOWN: r = {RCDL_PM_RES_DOWN, 1'b0};
        endcase
        return r;
    endfunction : reset_drive

    // This port's reset drive field, or analog if it has none
    function automatic logic [1:0] port_field(input logic [31:0] cfg);
        if (RDM_LSB == RCDL_NO_FIELD) begin
            return RCDL_RDM_HIZ_ANALOG;
        end
        return cfg[RDM_LSB +: 2];
    endfunction : port_field

    // Address phase accepted by this slave
    assign addr_take = hsel && hready && (htrans == RCDL_HTRANS_NONSEQ);

    // Effective mode and output bit per pin
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        logic [3:0] rst_drv;
        assign rst_drv = reset_drive(port_field(s_q.active_cfg));
        always_comb begin
            if (HAS_XRES && (i == XRES_PIN) && s_q.active_cfg[RCDL_XRES_BIT]) begin
                eff_mode[i] = RCDL_PM_HIZ_DIGITAL;
                eff_bit[i] = 1'b0;
            end else if (s_q.boot != RCDL_BOOT_RUN) begin
                eff_mode[i] = rst_drv[3:1];
                eff_bit[i] = rst_drv[0];
            end else begin
                eff_mode[i] = s_q.drive_mode[3*i +: 3];
                eff_bit[i] = s_q.hw_out_en[i] ? fabric_out[i] : s_q.data[i];
            end
        end
    end

    // Next-state logic: boot sequencer, register writes, pins, read data
    always_comb begin
        logic [31:0] wd;
        logic [3:0] drv;
        wd = hwdata;
        drv = 4'h0;
        s_d = s_q;
        lat_we = 1'b0;
        lat_waddr = s_q.dp_idx[RCDL_LAT_AW-1:0];
        lat_wdata = wd[7:0];

        // Copy one latch byte per cycle, then release the core
        unique case (s_q.boot)
            RCDL_BOOT_LOAD: begin
                s_d.active_cfg[8*s_q.load_idx +: 8] = lat_mem[s_q.load_idx];
                s_d.load_idx = s_q.load_idx + 1'b1;
                if (s_q.load_idx == RCDL_LAT_AW'(RCDL_LAT_BYTES - 1)) begin
                    s_d.boot = RCDL_BOOT_APPLY;
                end
            end
            RCDL_BOOT_APPLY: s_d.boot = RCDL_BOOT_RUN;
            RCDL_BOOT_RUN: s_d.boot = RCDL_BOOT_RUN;
        endcase

        // Data phase of a write
        if (s_q.dp_write) begin
            unique case (s_q.dp_idx)
                RCDL_IDX_DRIVE_LOW, RCDL_IDX_DRIVE_HIGH, RCDL_IDX_RESET_DEBUG, RCDL_IDX_BOOT_DEBUG: begin
                    lat_we = 1'b1; // Takes effect at the next reset
                    if (s_q.lat_writes != 16'hffff) begin
                        s_d.lat_writes = s_q.lat_writes + 16'h0001;
                    end
                end
                RCDL_IDX_DRIVE_MODE: s_d.drive_mode = wd[3*PINS-1:0];
                RCDL_IDX_DATA: s_d.data = wd[PINS-1:0];
                RCDL_IDX_HW_OUT_EN: s_d.hw_out_en = wd[PINS-1:0];
                RCDL_IDX_DIG_IN_EN: s_d.dig_in_en = wd[PINS-1:0];
                default: ;
            endcase
        end

        // Pin drivers and input path
        s_d.pin_state = pin_in;
        for (int i = 0; i < PINS; i++) begin
            drv = decode_drive(eff_mode[i], eff_bit[i]);
            s_d.pin_oe[i] = drv[3];
            s_d.pin_out[i] = drv[2];
            s_d.pin_pu[i] = drv[1];
            s_d.pin_pd[i] = drv[0];
            s_d.pin_an[i] = (eff_mode[i] == RCDL_PM_HIZ_ANALOG);
            s_d.fab_in[i] = pin_in[i] && s_q.dig_in_en[i] && (eff_mode[i] != RCDL_PM_HIZ_ANALOG)
                && (s_q.boot == RCDL_BOOT_RUN);
        end

        // External reset pin is active low
        s_d.ext_req = HAS_XRES && s_q.active_cfg[RCDL_XRES_BIT] && !s_q.pin_state[XRES_PIN];

        // Address phase: latch request, read from the updated values
        s_d.dp_write = addr_take && hwrite;
        if (addr_take) begin
            s_d.dp_idx = haddr[7:2];
        end
        if (addr_take && !hwrite) begin
            s_d.rdata = 32'h0;
            unique case (haddr[7:2])
                RCDL_IDX_DRIVE_LOW: s_d.rdata = {24'h0, lat_we && lat_waddr == 2'h0 ? lat_wdata : lat_mem[0]};
                RCDL_IDX_DRIVE_HIGH: s_d.rdata = {24'h0, lat_we && lat_waddr == 2'h1 ? lat_wdata : lat_mem[1]};
                RCDL_IDX_RESET_DEBUG: s_d.rdata = {24'h0, lat_we && lat_waddr == 2'h2 ? lat_wdata : lat_mem[2]};
                RCDL_IDX_BOOT_DEBUG: s_d.rdata = {24'h0, lat_we && lat_waddr == 2'h3 ? lat_wdata : lat_mem[3]};
                RCDL_IDX_DRIVE_MODE: s_d.rdata[3*PINS-1:0] = s_d.drive_mode;
                RCDL_IDX_DATA: s_d.rdata[PINS-1:0] = s_d.data;
                RCDL_IDX_HW_OUT_EN: s_d.rdata[PINS-1:0] = s_d.hw_out_en;
                RCDL_IDX_DIG_IN_EN: s_d.rdata[PINS-1:0] = s_d.dig_in_en;
                RCDL_IDX_PIN_STATE: s_d.rdata[PINS-1:0] = s_q.pin_state;
                RCDL_IDX_STATUS: begin
                    s_d.rdata[RCDL_ST_BOOT_DONE] = (s_q.boot == RCDL_BOOT_RUN);
                    s_d.rdata[RCDL_ST_XRES_ACTIVE] = s_q.ext_req;
                end
                RCDL_IDX_ACTIVE_CFG: s_d.rdata = s_q.active_cfg;
                RCDL_IDX_WRITE_COUNT: s_d.rdata[15:0] = s_d.lat_writes;
                default: s_d.rdata = 32'h0;
            endcase
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{boot: RCDL_BOOT_LOAD, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Latch array, written only by software, cleared to factory values
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            lat_mem[0] <= RCDL_DEF_BYTE0;
            lat_mem[1] <= RCDL_DEF_BYTE1;
            lat_mem[2] <= RCDL_DEF_BYTE2;
            lat_mem[3] <= DEF_BYTE3;
        end else if (lat_we) begin
            lat_mem[lat_waddr] <= lat_wdata;
        end
    end

    // Bus answer: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;

    // Pins and fabric
    assign pin_out = s_q.pin_out;
    assign pin_oe = s_q.pin_oe;
    assign pin_pull_up = s_q.pin_pu;
    assign pin_pull_down = s_q.pin_pd;
    assign pin_analog = s_q.pin_an;
    assign fabric_in = s_q.fab_in;

    // Applied configuration outputs
    assign core_reset_n = (s_q.boot == RCDL_BOOT_RUN);
    assign ext_reset_req = s_q.ext_req;
    assign ext_reset_pin_select = s_q.active_cfg[RCDL_XRES_BIT];
    assign debug_access_enable = s_q.active_cfg[RCDL_DBG_BIT];
    assign debug_port_select = s_q.active_cfg[RCDL_DPT_LSB +: 2];
    assign debug_port_enable = s_q.active_cfg[RCDL_DBG_BIT]
        && (s_q.active_cfg[RCDL_DPT_LSB +: 2] != RCDL_DPT_OFF);
    assign boot_clock_speed_select = s_q.active_cfg[RCDL_SPEED_BIT];
    assign flash_correction_enable = s_q.active_cfg[RCDL_ECC_BIT];
    assign digital_clock_phase_delay = s_q.active_cfg[RCDL_PHASE_LSB +: 4];

endmodule : rcdl_config_loader

// ### pkg/rcdl_pkg.sv
/*
 * Constants for the reset configuration loader: the register map of the
 * AHB-Lite slave, the layout of the four configuration latch bytes, the
 * factory defaults and the pin drive-mode codes.
 * Assumes a 32-bit AHB-Lite bus, one aligned word per register.
 */
package rcdl_pkg;

    // Latch array geometry
    localparam int RCDL_LAT_BYTES = 4;
    localparam int RCDL_LAT_AW = 2;

    // Printed latch indices; byte address is four times the index
    localparam logic [5:0] RCDL_IDX_DRIVE_LOW = 6'h00;
    localparam logic [5:0] RCDL_IDX_DRIVE_HIGH = 6'h01;
    localparam logic [5:0] RCDL_IDX_RESET_DEBUG = 6'h02;
    localparam logic [5:0] RCDL_IDX_BOOT_DEBUG = 6'h03;
    // Pin bank and status words (word indices)
    localparam logic [5:0] RCDL_IDX_DRIVE_MODE = 6'h04;
    localparam logic [5:0] RCDL_IDX_DATA = 6'h05;
    localparam logic [5:0] RCDL_IDX_HW_OUT_EN = 6'h06;
    localparam logic [5:0] RCDL_IDX_DIG_IN_EN = 6'h07;
    localparam logic [5:0] RCDL_IDX_PIN_STATE = 6'h08;
    localparam logic [5:0] RCDL_IDX_STATUS = 6'h09;
    localparam logic [5:0] RCDL_IDX_ACTIVE_CFG = 6'h0a;
    localparam logic [5:0] RCDL_IDX_WRITE_COUNT = 6'h0b;

    // Field positions inside the 32-bit applied configuration word
    localparam int RCDL_XRES_BIT = 23;
    localparam int RCDL_DBG_BIT = 22;
    localparam int RCDL_SPEED_BIT = 24;
    localparam int RCDL_DPT_LSB = 25;
    localparam int RCDL_ECC_BIT = 27;
    localparam int RCDL_PHASE_LSB = 28;
    localparam int RCDL_NO_FIELD = -1;

    // Status word bits
    localparam int RCDL_ST_BOOT_DONE = 0;
    localparam int RCDL_ST_XRES_ACTIVE = 1;

    // Factory defaults of the latch bytes
    localparam logic [7:0] RCDL_DEF_BYTE0 = 8'h00;
    localparam logic [7:0] RCDL_DEF_BYTE1 = 8'h00;
    localparam logic [7:0] RCDL_DEF_BYTE2 = 8'h40;
    localparam logic [7:0] RCDL_DEF_BYTE3 = 8'h0a;

    // Reset drive field codes
    localparam logic [1:0] RCDL_RDM_HIZ_ANALOG = 2'h0;
    localparam logic [1:0] RCDL_RDM_HIZ_DIGITAL = 2'h1;
    localparam logic [1:0] RCDL_RDM_PULL_UP = 2'h2;
    localparam logic [1:0] RCDL_RDM_PULL_DOWN = 2'h3;

    // Debug port select codes
    localparam logic [1:0] RCDL_DPT_OFF = 2'h3;

    // Pin drive-mode codes
    localparam logic [2:0] RCDL_PM_HIZ_ANALOG = 3'h0;
    localparam logic [2:0] RCDL_PM_HIZ_DIGITAL = 3'h1;
    localparam logic [2:0] RCDL_PM_RES_UP = 3'h2;
    localparam logic [2:0] RCDL_PM_RES_DOWN = 3'h3;
    localparam logic [2:0] RCDL_PM_OD_LOW = 3'h4;
    localparam logic [2:0] RCDL_PM_OD_HIGH = 3'h5;
    localparam logic [2:0] RCDL_PM_STRONG = 3'h6;
    localparam logic [2:0] RCDL_PM_RES_BOTH = 3'h7;

    // AHB transfer type
    localparam logic [1:0] RCDL_HTRANS_NONSEQ = 2'h2;

    // Boot sequencer states
    typedef enum logic [1:0] {RCDL_BOOT_LOAD, RCDL_BOOT_APPLY, RCDL_BOOT_RUN} rcdl_boot_t;

    // Bit position of a port's reset drive field, or none
    function automatic int rcdl_rdm_lsb(input int port);
        case (port)
            0: return 0;
            1: return 2;
            2: return 4;
            3: return 6;
            4: return 8;
            5: return 10;
            6: return 12;
            12: return 14;
            15: return 16;
            default: return RCDL_NO_FIELD;
        endcase
    endfunction : rcdl_rdm_lsb

endpackage : rcdl_pkg

// ### test/rcdl_config_loader_assertions.sv
/* Port checker for the reset configuration loader.
   Assumes a bind onto rcdl_config_loader and one hclk domain. */
`timescale 1ns/10ps
module rcdl_config_loader_assertions
    import rcdl_pkg::*;
#(
    parameter int PINS = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins
    input wire logic [PINS-1:0] fabric_in,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] pin_pull_up,
    input wire logic [PINS-1:0] pin_pull_down,
    input wire logic [PINS-1:0] pin_analog,
    // Applied configuration
    input wire logic core_reset_n,
    input wire logic ext_reset_req,
    input wire logic ext_reset_pin_select,
    input wire logic debug_access_enable,
    input wire logic [1:0] debug_port_select,
    input wire logic debug_port_enable,
    input wire logic boot_clock_speed_select,
    input wire logic flash_correction_enable,
    input wire logic [3:0] digital_clock_phase_delay
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Applied configuration as one vector
    wire [9:0] cfg = {ext_reset_pin_select, debug_access_enable, debug_port_select,
        boot_clock_speed_select, flash_correction_enable, digital_clock_phase_delay};

    // Boot holds the core for five edges, then runs
    sequence s_boot; !core_reset_n [*5]; endsequence
    sequence s_run; core_reset_n; endsequence
    property p_boot; $rose(hresetn) |-> s_boot ##1 s_run; endproperty
    a_boot: assert property (p_boot) else $error("boot length wrong");
    property p_cfg_hold; core_reset_n && $past(core_reset_n) |-> $stable(cfg); endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved while running");
    property p_dbg; debug_port_enable == (debug_access_enable && debug_port_select != RCDL_DPT_OFF); endproperty
    a_dbg: assert property (p_dbg) else $error("debug port enable wrong");
    property p_pull_excl; (pin_pull_up & pin_pull_down) == '0; endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
    property p_drive_excl; (pin_oe & (pin_pull_up | pin_pull_down)) == '0 &&
        (pin_analog & (pin_oe | pin_pull_up | pin_pull_down)) == '0; endproperty
    a_drive_excl: assert property (p_drive_excl) else $error("drive states overlap");
    property p_fab_in; (fabric_in & ~$past(pin_in)) == '0; endproperty
    a_fab_in: assert property (p_fab_in) else $error("fabric input without pin");
    property p_fab_boot; !core_reset_n |-> fabric_in == '0; endproperty
    a_fab_boot: assert property (p_fab_boot) else $error("fabric input during boot");
    property p_ext_req; ext_reset_req |-> ext_reset_pin_select; endproperty
    a_ext_req: assert property (p_ext_req) else $error("reset request while pin is io");
    property p_bus_ok; hreadyout && !hresp; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error");
    property p_hrdata;
        $changed(hrdata) |-> $past(hsel && hready && htrans == RCDL_HTRANS_NONSEQ && !hwrite);
    endproperty
    a_hrdata: assert property (p_hrdata) else $error("read data moved without read");
endmodule : rcdl_config_loader_assertions

// ### test/rcdl_pin_partner.sv
/* External circuitry on the port pins: resolves the device drive, the
   5K pulls and a bench-controlled source into the sampled pin level.
   Assumes the bench changes ext_en and ext_val just after rising edges. */
`timescale 1ns/10ps
module rcdl_pin_partner #(
    parameter int PINS = 8
) (
    // Clock
    input wire logic hclk,
    // Device pin drivers
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] pin_pull_up,
    input wire logic [PINS-1:0] pin_pull_down,
    // External source
    input wire logic [PINS-1:0] ext_en,
    input wire logic [PINS-1:0] ext_val,
    // Level seen by the device
    output logic [PINS-1:0] pin_in
);
    logic flip = 1'b0;

    // Floating pins wander, away from the sampling edge
    always @(negedge hclk) flip <= ~flip;

    // Strong drive wins, then the outside source, then the weak pulls
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pull_up[i]) pin_in[i] = 1'b1;
            else if (pin_pull_down[i]) pin_in[i] = 1'b0;
            else pin_in[i] = flip ^ i[0];
        end
    end
endmodule : rcdl_pin_partner

// ### test/rcdl_config_loader_tb.sv
/* Bench for the reset configuration loader: AHB-Lite master tasks,
   latch, boot and drive-mode scenarios. Assumes default parameters. */
`timescale 1ns/10ps
module rcdl_config_loader_tb;
    import rcdl_pkg::*;
    localparam int PINS = 8;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic por_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [PINS-1:0] fabric_out = '0;
    logic [PINS-1:0] ext_en = '0;
    logic [PINS-1:0] ext_val = '0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, core_reset_n, ext_reset_req, ext_reset_pin_select, debug_access_enable;
    logic debug_port_enable, boot_clock_speed_select, flash_correction_enable;
    logic [1:0] debug_port_select;
    logic [3:0] digital_clock_phase_delay;
    logic [PINS-1:0] fabric_in, pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_analog;
    int num_errors = 0;
    int cmp_count = 0;

    // Clock
    always #20 hclk = ~hclk;

    rcdl_config_loader rcdl_config_loader_inst (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .fabric_out, .fabric_in, .pin_in,
        .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_analog, .core_reset_n, .ext_reset_req,
        .ext_reset_pin_select, .debug_access_enable, .debug_port_select, .debug_port_enable,
        .boot_clock_speed_select, .flash_correction_enable, .digital_clock_phase_delay);
    rcdl_pin_partner #(.PINS(PINS)) rcdl_pin_partner_inst (.hclk, .pin_out, .pin_oe, .pin_pull_up,
        .pin_pull_down, .ext_en, .ext_val, .pin_in);

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // Single word transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= RCDL_HTRANS_NONSEQ;
        haddr <= {24'h0, idx, 2'h0};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic dev_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : dev_reset

    task automatic wait_boot();
        do @(posedge hclk); while (core_reset_n !== 1'b1);
        #1;
    endtask : wait_boot

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : settle

    // Expected {strong, pull up, pull down, analog}
    function automatic logic [3:0] dec(input logic [2:0] m, input logic d);
        case (m)
            3'h0: return 4'h1;
            3'h1: return 4'h0;
            3'h2: return d ? 4'h4 : 4'h8;
            3'h3: return d ? 4'h8 : 4'h2;
            3'h4: return d ? 4'h0 : 4'h8;
            3'h5: return d ? 4'h8 : 4'h0;
            3'h6: return 4'h8;
            default: return d ? 4'h4 : 4'h2;
        endcase
    endfunction : dec

    task automatic check_pins(input logic [23:0] m, input logic [7:0] d);
        logic [3:0] e;
        logic [4:0] s;
        for (int i = 0; i < PINS; i++) begin
            e = dec(m[3*i+:3], d[i]);
            s = {pin_oe[i], pin_pull_up[i], pin_pull_down[i], pin_analog[i], pin_out[i] & e[3]};
            chk("pin", s, {e, e[3] & d[i]});
        end
    endtask : check_pins

    task automatic t_defaults();
        logic [7:0] exp [4] = '{8'h00, 8'h00, 8'h40, 8'h0a};
        for (int i = 0; i < 4; i++) begin
            ahb(1'b0, 6'(i), '0);
            chk("latch", rd, {24'h0, exp[i]});
        end
        chk("xres", ext_reset_pin_select, 1'b0);
        chk("dbg", debug_access_enable, 1'b1);
        chk("speed", boot_clock_speed_select, 1'b0);
        chk("ecc", flash_correction_enable, 1'b1);
        chk("phase", digital_clock_phase_delay, 4'h0);
        ahb(1'b0, RCDL_IDX_STATUS, '0);
        chk("boot", rd[0], 1'b1);
        ahb(1'b0, 6'h3f, '0);
        chk("unmapped", rd, 32'h0);
        $display("t_defaults done");
    endtask : t_defaults

    task automatic t_drive_modes();
        ahb(1'b1, RCDL_IDX_HW_OUT_EN, '0);
        ahb(1'b1, RCDL_IDX_DRIVE_MODE, 32'hfac688);
        for (int k = 0; k < 2; k++) begin
            ahb(1'b1, RCDL_IDX_DATA, k ? 32'haa : 32'h55);
            settle(2);
            check_pins(24'hfac688, k ? 8'haa : 8'h55);
        end
        $display("t_drive_modes done");
    endtask : t_drive_modes

    task automatic t_fabric();
        ahb(1'b1, RCDL_IDX_DRIVE_MODE, 32'hdb6db6);
        fabric_out <= 8'h3c;
        ahb(1'b1, RCDL_IDX_DATA, 32'hc3);
        ahb(1'b1, RCDL_IDX_HW_OUT_EN, 32'h0f);
        settle(2);
        chk("out_sel", pin_out, 8'hcc);
        ahb(1'b1, RCDL_IDX_DRIVE_MODE, 32'h249249);
        ext_en <= 8'hff;
        ext_val <= 8'ha5;
        ahb(1'b1, RCDL_IDX_DIG_IN_EN, 32'h0f);
        settle(3);
        chk("fab_in", fabric_in, 8'h05);
        ext_val <= 8'h5a;
        ahb(1'b1, RCDL_IDX_DIG_IN_EN, 32'h0);
        settle(3);
        chk("fab_off", fabric_in, 8'h00);
        ahb(1'b0, RCDL_IDX_PIN_STATE, '0);
        chk("state", rd, 32'h5a);
        ext_en <= 8'h00;
        $display("t_fabric done");
    endtask : t_fabric

    task automatic t_reset_drive();
        logic [1:0] f;
        for (int c = 0; c < 4; c++) begin
            f = 2'(c);
            ahb(1'b1, RCDL_IDX_DRIVE_LOW, {24'h0, {4{f}}});
            ahb(1'b1, RCDL_IDX_BOOT_DEBUG, {24'h0, 5'h1, f, 1'b0});
            dev_reset();
            settle(4);
            chk("boot_hold", core_reset_n, 1'b0);
            check_pins({8{1'b0, f}}, {8{~f[0]}});
            wait_boot();
            chk("dport", debug_port_select, f);
            chk("dpe", debug_port_enable, f != 2'h3);
        end
        $display("t_reset_drive done");
    endtask : t_reset_drive

    task automatic t_config();
        ahb(1'b1, RCDL_IDX_DRIVE_LOW, 32'haa);
        ahb(1'b1, RCDL_IDX_RESET_DEBUG, 32'h80);
        ahb(1'b1, RCDL_IDX_BOOT_DEBUG, 32'hf7);
        ahb(1'b0, RCDL_IDX_BOOT_DEBUG, '0);
        chk("readback", rd, 32'hf7);
        chk("not_yet", boot_clock_speed_select, 1'b0);
        ahb(1'b0, RCDL_IDX_WRITE_COUNT, '0);
        chk("wcount", rd, 32'h3);
        dev_reset();
        wait_boot();
        chk("xres", ext_reset_pin_select, 1'b1);
        chk("dbg", debug_access_enable, 1'b0);
        chk("speed", boot_clock_speed_select, 1'b1);
        chk("ecc", flash_correction_enable, 1'b0);
        chk("phase", digital_clock_phase_delay, 4'hf);
        ahb(1'b0, RCDL_IDX_DRIVE_LOW, '0);
        chk("kept", rd, 32'haa);
        ahb(1'b1, RCDL_IDX_DRIVE_MODE, 32'h249249);
        ext_en <= 8'h04;
        ext_val <= 8'h00;
        settle(3);
        chk("xreq", ext_reset_req, 1'b1);
        ahb(1'b0, RCDL_IDX_STATUS, '0);
        chk("xstat", rd[1], 1'b1);
        ext_val <= 8'h04;
        settle(3);
        chk("xreq_off", ext_reset_req, 1'b0);
        $display("t_config done");
    endtask : t_config

    // Main sequence
    initial begin
        repeat (2) @(posedge hclk);
        por_n <= 1'b1;
        hresetn <= 1'b1;
        wait_boot();
        t_defaults();
        t_drive_modes();
        t_fabric();
        t_reset_drive();
        t_config();
        report_and_stop();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule : rcdl_config_loader_tb

bind rcdl_config_loader rcdl_config_loader_assertions #(.PINS(PINS)) rcdl_config_loader_assertions_inst (
    .hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .hrdata, .hreadyout, .hresp, .fabric_in, .pin_in,
    .pin_oe, .pin_pull_up, .pin_pull_down, .pin_analog, .core_reset_n, .ext_reset_req, .ext_reset_pin_select,
    .debug_access_enable, .debug_port_select, .debug_port_enable, .boot_clock_speed_select,
    .flash_correction_enable, .digital_clock_phase_delay);
